// ---- cimap_pkg.sv ----
// Constants and types for the contact I/O function mapper
package cimap_pkg;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned TICK_NS = 1000000;
    localparam int unsigned TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    localparam int unsigned MIN_PULSE_MS = 1500;
    localparam int unsigned BLOW_MIN_MS = 1000;
    localparam int unsigned BLOW_MAX_MS = 11000;
    localparam int unsigned DEBOUNCE_MS = 20;
    localparam int unsigned WID_W = 16;
    localparam int unsigned DB_W = 8;
    // ----------------------------------------
    // Sizes
    // ----------------------------------------
    localparam int unsigned N_IN = 8;
    localparam int unsigned N_OUT = 8;
    localparam int unsigned N_ALARM = 6;
    localparam int unsigned N_CH = 5;
    localparam int unsigned VAL_W = 16;
    localparam int unsigned FN_W = 4;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_OUT_SEL = 8'h04;
    localparam logic [7:0] ADDR_IN_SEL = 8'h08;
    localparam logic [7:0] ADDR_ALARM_CFG = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_FLAGS = 8'h14;
    localparam logic [7:0] ADDR_LIMIT_BASE = 8'h40;
    localparam logic [7:0] ADDR_LIMIT_END = 8'h9c;
    localparam int unsigned CTRL_SAMPLING_BIT = 0;
    localparam int unsigned CTRL_EXT_O2_BIT = 1;
    localparam int unsigned CTRL_REMOTE_LSB = 8;
    localparam int unsigned CTRL_LOCAL_LSB = 16;
    localparam int unsigned ALARM_CFG_STEP = 5;
    localparam int unsigned STATUS_RANGE_LSB = 8;
    localparam int unsigned STATUS_ALARM_LSB = 16;
    localparam int unsigned STATUS_HOLD_BIT = 24;
    localparam logic [31:0] CTRL_RESET = 32'h001f_0000;
    localparam logic [31:0] SEL_RESET = 32'h0000_0000;
    localparam logic [29:0] ALARM_CFG_RESET = 30'h0000_0000;
    localparam logic [VAL_W-1:0] HIGH_LIMIT_RESET = 16'hffff;
    localparam logic [VAL_W-1:0] LOW_LIMIT_RESET = 16'h0000;
    // ----------------------------------------
    // Function codes
    // ----------------------------------------
    typedef enum logic [3:0] {
        OUT_NONE = 4'h0, OUT_ALARM1 = 4'h1, OUT_ALARM6 = 4'h6,
        OUT_PEAK = 4'h7, OUT_SWITCH = 4'h8, OUT_MAINT = 4'h9,
        OUT_POWER = 4'ha, OUT_SYS_VAL = 4'hb, OUT_SYS_CAL = 4'hc,
        OUT_O2_SPAN = 4'hd
    } cimap_out_fn_t;
    typedef enum logic [3:0] {
        IN_NONE = 4'h0, IN_HOLD = 4'h1, IN_AVG_RESET = 4'h2,
        IN_CAL_START = 4'h3, IN_ZERO_START = 4'h4, IN_VAL_START = 4'h5,
        IN_PRIMARY_SPAN = 4'h6, IN_RANGE5 = 4'ha, IN_BLOWBACK = 4'hb,
        IN_O2_DONE = 4'hc, IN_O2_ERROR = 4'hd
    } cimap_in_fn_t;
    typedef enum logic [1:0] {
        MODE_OFF = 2'h0, MODE_HIGH = 2'h1, MODE_LOW = 2'h2, MODE_BOTH = 2'h3
    } cimap_mode_t;
endpackage

// ---- cimap_mapper.sv ----
// Contact I/O function mapper: alarm/state contacts and qualified inputs
// Behaviour
// - Six alarm contacts, each asserted only while its limit condition holds.
// - High mode asserts above the high limit of the active range.
// - Low mode asserts below the low limit of the active range.
// - Combined mode asserts above high or below low limit.
// - Peak count contact follows the peak count alarm condition.
// - Switchover on when measuring; in cal/val off, or on for sampling path.
// - Maintenance contact on during maintenance, calibration, validation, blowback.
// - Power status contact asserted while powered, low only during reset.
// - System validation contact on during auto validation, sampling path only.
// - System calibration contact on during any calibration, sampling path only.
// - Each of eight inputs takes one function; functions may repeat.
// - Hold input freezes analog outputs while contact stays closed.
// - Average reset pulse of 1.5 s or more clears all averages together.
// - Calibration start pulse of 1.5 s or more launches auto calibration.
// - Zero start pulse of 1.5 s or more launches the auto sequence.
// - Validation start pulse of 1.5 s or more launches auto validation.
// - Remote range channels: closed selects primary, open selects secondary.
// - Blowback pulse accepted only between 1.0 s and 11.0 s.
// - Falling edge ends external O2 cal; auto cal refused if unassigned.
// - O2 error level sampled at external cal completion; none if unassigned.
// - Span contact for external O2 channel commands its cal in auto cal.
`timescale 1ns/1ps
module cimap_mapper #(
    parameter int unsigned TICK_CYCLES = cimap_pkg::TICK_CYCLES,
    parameter int unsigned MIN_PULSE_MS = cimap_pkg::MIN_PULSE_MS,
    parameter int unsigned BLOW_MIN_MS = cimap_pkg::BLOW_MIN_MS,
    parameter int unsigned BLOW_MAX_MS = cimap_pkg::BLOW_MAX_MS,
    parameter int unsigned DEBOUNCE_MS = cimap_pkg::DEBOUNCE_MS
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [cimap_pkg::N_IN-1:0] contact_in,
    input wire logic [cimap_pkg::N_CH*cimap_pkg::VAL_W-1:0] meas_value,
    input wire logic st_measuring,
    input wire logic st_maintenance,
    input wire logic st_cal_manual,
    input wire logic st_cal_auto,
    input wire logic st_cal_zero,
    input wire logic st_val_auto,
    input wire logic st_blowback,
    input wire logic peak_alarm,
    input wire logic o2_span_req,
    output logic [cimap_pkg::N_OUT-1:0] contact_out,
    output logic hold_outputs,
    output logic [cimap_pkg::N_CH-1:0] range_primary,
    output logic avg_reset,
    output logic cal_start,
    output logic zero_start,
    output logic val_start,
    output logic blow_start,
    output logic o2_cal_done,
    output logic o2_cal_error
);
    import cimap_pkg::*;

    // ----------------------------------------
    // Registers and APB slave
    // ----------------------------------------
    logic [31:0] ctrl;
    logic [31:0] out_sel;
    logic [31:0] in_sel;
    logic [29:0] alarm_cfg;
    logic [VAL_W-1:0] limit [N_ALARM*4];
    logic refused;
    logic [N_ALARM-1:0] alarm_q;
    logic refuse_now;
    logic setup;
    logic wr_ok;
    logic mapped;
    logic lim_hit;
    logic [4:0] lim_idx;
    logic [31:0] next_rdata;

    assign setup = psel && !penable;
    assign wr_ok = psel && penable && pready && pwrite && !pslverr;
    assign lim_hit = paddr >= ADDR_LIMIT_BASE && paddr <= ADDR_LIMIT_END
        && paddr[1:0] == 2'b00;
    assign lim_idx = 5'(paddr[7:2] - ADDR_LIMIT_BASE[7:2]);

    always_comb begin
        next_rdata = 32'h0000_0000;
        mapped = 1'b1;
        case (paddr)
            ADDR_CTRL: next_rdata = ctrl;
            ADDR_OUT_SEL: next_rdata = out_sel;
            ADDR_IN_SEL: next_rdata = in_sel;
            ADDR_ALARM_CFG: next_rdata = {2'b00, alarm_cfg};
            ADDR_STATUS: next_rdata = {7'h00, hold_outputs, 2'b00, alarm_q,
                3'b000, range_primary, contact_out};
            ADDR_FLAGS: next_rdata = {31'h0000_0000, refused};
            default: begin
                if (lim_hit) begin
                    next_rdata = {16'h0000, limit[lim_idx]};
                end else begin
                    mapped = 1'b0;
                end
            end
        endcase
    end

    // No wait state: data is latched in setup, answered in access
    always_ff @(posedge clk) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= setup && !mapped;
            if (setup && !pwrite) begin
                prdata <= next_rdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl <= CTRL_RESET;
            out_sel <= SEL_RESET;
            in_sel <= SEL_RESET;
            alarm_cfg <= ALARM_CFG_RESET;
        end else if (wr_ok) begin
            case (paddr)
                ADDR_CTRL: ctrl <= pwdata;
                ADDR_OUT_SEL: out_sel <= pwdata;
                ADDR_IN_SEL: in_sel <= pwdata;
                ADDR_ALARM_CFG: alarm_cfg <= pwdata[29:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            for (int k = 0; k < N_ALARM * 4; k++) begin
                limit[k] <= k[1] ? LOW_LIMIT_RESET : HIGH_LIMIT_RESET;
            end
        end else if (wr_ok && lim_hit) begin
            limit[lim_idx] <= pwdata[VAL_W-1:0];
        end
    end

    // Refusal flag: write one to clear, a new refusal wins
    always_ff @(posedge clk) begin
        if (reset) begin
            refused <= 1'b0;
        end else if (refuse_now) begin
            refused <= 1'b1;
        end else if (wr_ok && paddr == ADDR_FLAGS && pwdata[0]) begin
            refused <= 1'b0;
        end
    end

    // ----------------------------------------
    // Timebase and input qualification
    // ----------------------------------------
    logic [31:0] tick_cnt;
    logic tick;
    logic [N_IN-1:0] db;
    logic [N_IN-1:0] ok_min;
    logic [N_IN-1:0] ok_blow;
    logic [N_IN-1:0] fell;

    assign tick = tick_cnt == 32'(TICK_CYCLES - 1);

    always_ff @(posedge clk) begin
        if (reset || tick) begin
            tick_cnt <= 32'h0000_0000;
        end else begin
            tick_cnt <= tick_cnt + 32'h0000_0001;
        end
    end

    for (genvar i = 0; i < N_IN; i++) begin : g_in
        logic [DB_W-1:0] db_cnt;
        logic [WID_W-1:0] wid;
        logic fall_now;
        assign fall_now = db[i] && db_cnt == DB_W'(DEBOUNCE_MS - 1)
            && tick && !contact_in[i];
        // stable for the debounce time before a level changes
        always_ff @(posedge clk) begin
            if (reset) begin
                db[i] <= 1'b0;
                db_cnt <= '0;
            end else if (contact_in[i] == db[i]) begin
                db_cnt <= '0;
            end else if (tick) begin
                if (db_cnt == DB_W'(DEBOUNCE_MS - 1)) begin
                    db[i] <= contact_in[i];
                    db_cnt <= '0;
                end else begin
                    db_cnt <= db_cnt + 1'b1;
                end
            end
        end
        // Width counter saturates so very long closures stay out of window
        always_ff @(posedge clk) begin
            if (reset || !db[i]) begin
                wid <= '0;
            end else if (tick && wid != '1) begin
                wid <= wid + 1'b1;
            end
        end
        // widths judged on release, bad widths dropped
        always_ff @(posedge clk) begin
            if (reset) begin
                ok_min[i] <= 1'b0;
                ok_blow[i] <= 1'b0;
                fell[i] <= 1'b0;
            end else begin
                fell[i] <= fall_now;
                ok_min[i] <= fall_now && wid >= WID_W'(MIN_PULSE_MS);
                ok_blow[i] <= fall_now && wid >= WID_W'(BLOW_MIN_MS)
                    && wid <= WID_W'(BLOW_MAX_MS);
            end
        end
    end

    // ----------------------------------------
    // Input functions
    // ----------------------------------------
    logic hold_any;
    logic avg_any;
    logic cal_any;
    logic zero_any;
    logic val_any;
    logic blow_any;
    logic done_any;
    logic err_any;
    logic done_assigned;
    logic [N_CH-1:0] rng_closed;
    logic [N_CH-1:0] rng_assigned;
    logic [N_CH-1:0] next_range;

    always_comb begin
        hold_any = 1'b0;
        avg_any = 1'b0;
        cal_any = 1'b0;
        zero_any = 1'b0;
        val_any = 1'b0;
        blow_any = 1'b0;
        done_any = 1'b0;
        err_any = 1'b0;
        done_assigned = 1'b0;
        rng_closed = '0;
        rng_assigned = '0;
        for (int i = 0; i < N_IN; i++) begin
            case (in_sel[i*FN_W +: FN_W])
                IN_HOLD: hold_any |= db[i];
                IN_AVG_RESET: avg_any |= ok_min[i];
                IN_CAL_START: cal_any |= ok_min[i];
                IN_ZERO_START: zero_any |= ok_min[i];
                IN_VAL_START: val_any |= ok_min[i];
                IN_BLOWBACK: blow_any |= ok_blow[i];
                IN_O2_DONE: begin
                    done_any |= fell[i];
                    done_assigned = 1'b1;
                end
                IN_O2_ERROR: err_any |= db[i];
                default: ;
            endcase
            for (int c = 0; c < N_CH; c++) begin
                if (in_sel[i*FN_W +: FN_W] == FN_W'(IN_PRIMARY_SPAN + c)) begin
                    rng_closed[c] |= db[i];
                    rng_assigned[c] = 1'b1;
                end
            end
        end
    end

    // remote channels follow the contact, others the local choice
    always_comb begin
        for (int c = 0; c < N_CH; c++) begin
            next_range[c] = (ctrl[CTRL_REMOTE_LSB + c] && rng_assigned[c])
                ? rng_closed[c] : ctrl[CTRL_LOCAL_LSB + c];
        end
    end

    // no completion input means an external O2 cal cannot finish
    assign refuse_now = cal_any && ctrl[CTRL_EXT_O2_BIT] && !done_assigned;

    always_ff @(posedge clk) begin
        if (reset) begin
            hold_outputs <= 1'b0;
            range_primary <= '0;
            avg_reset <= 1'b0;
            cal_start <= 1'b0;
            zero_start <= 1'b0;
            val_start <= 1'b0;
            blow_start <= 1'b0;
            o2_cal_done <= 1'b0;
            o2_cal_error <= 1'b0;
        end else begin
            hold_outputs <= hold_any;
            range_primary <= next_range;
            // one pulse clears every average at once
            avg_reset <= avg_any;
            cal_start <= cal_any && !refuse_now;
            zero_start <= zero_any;
            val_start <= val_any;
            blow_start <= blow_any;
            o2_cal_done <= done_any;
            o2_cal_error <= done_any && err_any;
        end
    end

    // ----------------------------------------
    // Alarms and contact outputs
    // ----------------------------------------
    logic [N_ALARM-1:0] next_alarm;
    logic cal_any_state;
    logic [N_OUT-1:0] next_out;

    always_comb begin
        for (int a = 0; a < N_ALARM; a++) begin
            logic [2:0] ch;
            logic [VAL_W-1:0] v;
            logic [VAL_W-1:0] hi;
            logic [VAL_W-1:0] lo;
            logic above;
            logic below;
            ch = alarm_cfg[a*ALARM_CFG_STEP+2 +: 3];
            if (ch >= 3'(N_CH)) begin
                ch = 3'h0;
            end
            v = meas_value[ch*VAL_W +: VAL_W];
            hi = limit[a*4 + (next_range[ch] ? 0 : 1)];
            lo = limit[a*4 + (next_range[ch] ? 2 : 3)];
            above = v > hi;
            below = v < lo;
            // asserted only while the condition holds
            case (cimap_mode_t'(alarm_cfg[a*ALARM_CFG_STEP +: 2]))
                MODE_HIGH: next_alarm[a] = above;
                MODE_LOW: next_alarm[a] = below;
                MODE_BOTH: next_alarm[a] = above || below;
                default: next_alarm[a] = 1'b0;
            endcase
        end
    end

    assign cal_any_state = st_cal_manual || st_cal_auto || st_cal_zero;

    always_comb begin
        for (int o = 0; o < N_OUT; o++) begin
            logic [FN_W-1:0] fn;
            fn = out_sel[o*FN_W +: FN_W];
            case (fn)
                OUT_PEAK: next_out[o] = peak_alarm;
                // variant picked by gas path setting
                OUT_SWITCH: next_out[o] = st_measuring ? 1'b1
                    : ((cal_any_state || st_val_auto)
                    && ctrl[CTRL_SAMPLING_BIT]);
                OUT_MAINT: next_out[o] = st_maintenance || cal_any_state
                    || st_val_auto || st_blowback;
                OUT_POWER: next_out[o] = 1'b1;
                OUT_SYS_VAL: next_out[o] = ctrl[CTRL_SAMPLING_BIT]
                    && st_val_auto;
                OUT_SYS_CAL: next_out[o] = ctrl[CTRL_SAMPLING_BIT]
                    && cal_any_state;
                // span contact commands the external analyzer
                OUT_O2_SPAN: next_out[o] = st_cal_auto && o2_span_req;
                default: begin
                    next_out[o] = 1'b0;
                    if (fn >= OUT_ALARM1 && fn <= OUT_ALARM6) begin
                        next_out[o] = next_alarm[3'(fn - OUT_ALARM1)];
                    end
                end
            endcase
        end
    end

    // Power contact reads low only during reset; no earlier state exists
    always_ff @(posedge clk) begin
        if (reset) begin
            contact_out <= '0;
            alarm_q <= '0;
        end else begin
            contact_out <= next_out;
            alarm_q <= next_alarm;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    power_contact_a: assert property (
        @(posedge clk) disable iff (reset)
        out_sel[3:0] == OUT_POWER && $past(out_sel[3:0] == OUT_POWER)
        && !$past(reset) |-> contact_out[0])
        else $error("power contact not asserted");
    hold_follow_a: assert property (
        @(posedge clk) disable iff (reset)
        ##1 hold_outputs == $past(hold_any))
        else $error("hold does not follow input");
    avg_pulse_a: assert property (
        @(posedge clk) disable iff (reset)
        avg_reset |=> !avg_reset)
        else $error("average reset longer than one cycle");
    cal_refuse_a: assert property (
        @(posedge clk) disable iff (reset)
        cal_start |-> $past(!ctrl[CTRL_EXT_O2_BIT] || done_assigned))
        else $error("auto cal started without completion input");
    o2_error_a: assert property (
        @(posedge clk) disable iff (reset)
        o2_cal_error |-> o2_cal_done && $past(err_any))
        else $error("O2 error outside completion");
    blow_window_a: assert property (
        @(posedge clk) disable iff (reset)
        $rose(fell[0]) && ok_blow[0] |-> $past(g_in[0].wid) >=
        WID_W'(BLOW_MIN_MS) && $past(g_in[0].wid) <= WID_W'(BLOW_MAX_MS))
        else $error("blowback width out of window");
    range_remote_a: assert property (
        @(posedge clk) disable iff (reset)
        ctrl[CTRL_REMOTE_LSB] && rng_assigned[0] && $stable(db)
        && $stable(in_sel) |=> range_primary[0] == $past(rng_closed[0]))
        else $error("remote range not following contact");
    maint_contact_a: assert property (
        @(posedge clk) disable iff (reset)
        out_sel[11:8] == OUT_MAINT && st_blowback ##1
        out_sel[11:8] == OUT_MAINT |-> contact_out[2])
        else $error("maintenance contact missing in blowback");
    sys_cal_a: assert property (
        @(posedge clk) disable iff (reset)
        out_sel[23:20] == OUT_SYS_CAL && !ctrl[CTRL_SAMPLING_BIT]
        |=> !contact_out[5])
        else $error("system cal contact without sampling path");
endmodule // cimap_mapper

// ---- cimap_contact_panel.sv ----
// Far-side panel model that opens and closes the dry contact inputs
`timescale 1ns/1ps
module cimap_contact_panel #(
    parameter int unsigned TICK = 10
) (
    input wire logic clk,
    output logic [7:0] contact
);
    initial begin
        contact = 8'h00;
    end
    task automatic press(input int idx, input int ticks);
        @(posedge clk);
        contact[idx] <= 1'b1;
        repeat (ticks * TICK) @(posedge clk);
        contact[idx] <= 1'b0;
        // Long open gap, so debounce can never merge two presses
        repeat (8 * TICK) @(posedge clk);
    endtask
    task automatic level(input logic [7:0] m);
        @(posedge clk);
        contact <= m;
    endtask
endmodule // cimap_contact_panel

// ---- cimap_mapper_tb.sv ----
// Self-checking testbench for the contact function mapper
`timescale 1ns/1ps
module cimap_mapper_tb;
    import cimap_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [79:0] meas_value = 80'h0;
    logic [8:0] st = 9'h000;
    logic [31:0] prdata, rdat;
    logic pready, pslverr, rerr, hold_outputs, o2_cal_done, o2_cal_error;
    logic avg_reset, cal_start, zero_start, val_start, blow_start;
    logic [7:0] contact_in, contact_out;
    logic [4:0] range_primary;
    int n [7] = '{0, 0, 0, 0, 0, 0, 0};
    int miscompares = 0;
    int num_checks = 0;
    always #5 clk = ~clk;
    always @(posedge clk) begin
        n[0] <= n[0] + (avg_reset === 1'b1);
        n[1] <= n[1] + (blow_start === 1'b1);
        n[2] <= n[2] + (cal_start === 1'b1);
        n[3] <= n[3] + (zero_start === 1'b1);
        n[4] <= n[4] + (val_start === 1'b1);
        n[5] <= n[5] + (o2_cal_done === 1'b1);
        n[6] <= n[6] + (o2_cal_error === 1'b1);
    end
    // Short timebase so 1.5 s shrinks to 15 ticks of 10 clocks
    cimap_mapper #(.TICK_CYCLES(10), .MIN_PULSE_MS(15), .BLOW_MIN_MS(10),
        .BLOW_MAX_MS(110), .DEBOUNCE_MS(2)) cimap_mapper_i (
        .clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .contact_in(contact_in),
        .meas_value(meas_value), .st_measuring(st[0]),
        .st_maintenance(st[1]), .st_cal_manual(st[2]), .st_cal_auto(st[3]),
        .st_cal_zero(st[4]), .st_val_auto(st[5]), .st_blowback(st[6]),
        .peak_alarm(st[7]), .o2_span_req(st[8]), .contact_out(contact_out),
        .hold_outputs(hold_outputs), .range_primary(range_primary),
        .avg_reset(avg_reset), .cal_start(cal_start),
        .zero_start(zero_start), .val_start(val_start),
        .blow_start(blow_start), .o2_cal_done(o2_cal_done),
        .o2_cal_error(o2_cal_error));
    cimap_contact_panel cimap_contact_panel_i (
        .clk(clk), .contact(contact_in));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        int w;
        w = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && w < 20) begin
            w++;
            @(posedge clk);
        end
        check(32'(w < 20), 32'h1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic so(input logic [8:0] s, input logic [7:0] e);
        st <= s;
        repeat (3) @(posedge clk);
        check(32'(contact_out), 32'(e));
    endtask
    task automatic mv(input logic [15:0] v, input logic e);
        meas_value <= {64'h0, v};
        repeat (3) @(posedge clk);
        check(32'(contact_out[4]), 32'(e));
    endtask
    task automatic pc(input int idx, input int ticks, input logic [4:0] e);
        int b [7];
        b = n;
        cimap_contact_panel_i.press(idx, ticks);
        for (int j = 0; j < 5; j++) begin
            check(32'(n[j] - b[j]), 32'(e[j]));
        end
    endtask
    task automatic lv(input logic [7:0] m, input logic [1:0] e);
        cimap_contact_panel_i.level(m);
        repeat (60) @(posedge clk);
        check(32'({hold_outputs, range_primary[0]}), 32'(e));
    endtask
    // Short press on the O2 completion input; e = {error, done}
    task automatic od(input logic [1:0] e);
        int b [7];
        b = n;
        cimap_contact_panel_i.press(0, 5);
        check(32'(n[5] - b[5]), 32'(e[0]));
        check(32'(n[6] - b[6]), 32'(e[1]));
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs;
        apb(1'b0, ADDR_CTRL, 32'h0);
        check(rdat, CTRL_RESET);
        apb(1'b0, 8'h20, 32'h0);
        check(32'(rerr), 32'h1);
    endtask
    task automatic t_state;
        apb(1'b1, ADDR_OUT_SEL, 32'hdbc1897a);
        so(9'h000, 8'h01);
        so(9'h080, 8'h03);
        so(9'h001, 8'h09);
        so(9'h008, 8'h05);
        apb(1'b1, ADDR_CTRL, 32'h001f0001);
        so(9'h008, 8'h2d);
        so(9'h020, 8'h4d);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check(rdat, 32'h0000_1f4d);
        so(9'h040, 8'h05);
        so(9'h108, 8'had);
        so(9'h100, 8'h01);
    endtask
    task automatic t_alarm;
        logic [15:0] v [4] = '{16'd49, 16'd50, 16'd100, 16'd101};
        apb(1'b1, ADDR_LIMIT_BASE, 32'd100);
        apb(1'b1, ADDR_LIMIT_BASE + 8'h08, 32'd50);
        for (int m = 1; m < 4; m++) begin
            apb(1'b1, ADDR_ALARM_CFG, 32'(m));
            for (int k = 0; k < 4; k++) begin
                mv(v[k], (m[0] && v[k] > 100) || (m[1] && v[k] < 50));
            end
        end
        apb(1'b1, ADDR_LIMIT_BASE + 8'h04, 32'd200);
        apb(1'b1, ADDR_CTRL, 32'h001e0001);
        apb(1'b1, ADDR_ALARM_CFG, 32'h1);
        mv(16'd150, 1'b0);
        mv(16'd201, 1'b1);
    endtask
    task automatic t_pulse;
        apb(1'b1, ADDR_IN_SEL, 32'h543621b2);
        apb(1'b1, ADDR_CTRL, 32'h001f0100);
        pc(0, 20, 5'b00001);
        pc(0, 8, 5'b00000);
        pc(3, 20, 5'b00001);
        pc(5, 20, 5'b00100);
        pc(6, 20, 5'b01000);
        pc(7, 20, 5'b10000);
        pc(1, 60, 5'b00010);
        pc(1, 5, 5'b00000);
        pc(1, 150, 5'b00000);
        lv(8'h14, 2'b11);
        lv(8'h00, 2'b00);
    endtask
    task automatic t_o2;
        apb(1'b1, ADDR_CTRL, 32'h001f0002);
        pc(5, 20, 5'b00000);
        apb(1'b0, ADDR_FLAGS, 32'h0);
        check(rdat, 32'h1);
        apb(1'b1, ADDR_FLAGS, 32'h1);
        apb(1'b0, ADDR_FLAGS, 32'h0);
        check(rdat, 32'h0);
        apb(1'b1, ADDR_IN_SEL, 32'h543621dc);
        pc(5, 20, 5'b00100);
        lv(8'h02, 2'b01);
        od(2'b11);
        lv(8'h00, 2'b01);
        od(2'b01);
    endtask
    task automatic stop_test;
        if (miscompares == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Whole run needs about 5200 clocks; nearly four times that is a hang
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        stop_test;
    end
    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        t_regs;
        t_state;
        t_alarm;
        t_pulse;
        t_o2;
        stop_test;
    end
endmodule // cimap_mapper_tb
